// ==== rtl/rpu_top.sv ====
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rpu_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [rpu_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [rpu_pkg::WORD_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [rpu_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [rpu_pkg::WORD_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [rpu_pkg::WORD_W-1:0] word_data,
    input wire logic word_valid,
    output logic word_ready,
    input wire logic frame_start,
    output logic [rpu_pkg::PIX_W-1:0] pix_data,
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [rpu_pkg::WORD_W-1:0] cur_rd_addr,
    input wire logic [rpu_pkg::WORD_W-1:0] cur_rd_data,
    output logic bright,
    output logic dual_scan_enable
);
    import rpu_pkg::*;

    logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic [ADDR_W-1:0] waddr_ff, nxt_waddr;
    logic [WORD_W-1:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata, rd_word;
    logic [3:0] wstrb_ff, nxt_wstrb, wr_idx, rd_idx;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic wr_go, wr_ok, rd_ok;
    logic [WORD_W-1:0] regs_ff [0:NREG_RW-1];
    logic [WORD_W-1:0] nxt_regs [0:NREG_RW-1];

    // Write address and data are taken in either order, then answered.
    assign awready = !aw_got_ff && !bvalid_ff;
    assign wready = !w_got_ff && !bvalid_ff;
    assign arready = !rvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_idx = waddr_ff[5:2];
    assign rd_idx = araddr[5:2];
    assign wr_ok = waddr_ff[ADDR_W-1:6] == '0 && wr_idx < 4'(NREG_RW);
    assign rd_ok = araddr[ADDR_W-1:6] == '0 && rd_idx < 4'(NREG);

    logic [2:0] depth;
    logic cur_en, fsync, run;
    logic [COORD_W-1:0] scr_w, scr_h, cur_x, cur_y, x_ff, y_ff;
    logic [6:0] cw, ch;
    logic [PWM_W-1:0] pwm_per, pwm_duty;

    // Read data mux; the status word shows the live pixel position.
    always_comb begin
        rd_word = '0;
        if (rd_idx == IDX_STATUS) begin
            rd_word = {5'h00, y_ff, 5'h00, x_ff};
        end else if (rd_idx < 4'(NREG_RW)) begin
            rd_word = regs_ff[rd_idx];
        end
    end

    // Bus handshake next state; unmapped or read-only writes get SLVERR.
    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (awvalid && awready) begin
            nxt_aw_got = 1'b1;
            nxt_waddr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_w_got = 1'b1;
            nxt_wdata = wdata;
            nxt_wstrb = wstrb;
        end
        if (wr_go) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_ok ? rd_word : '0;
            nxt_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // Register file write with byte strobes.
    always_comb begin
        nxt_regs = regs_ff;
        if (wr_go && wr_ok) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_ff[b]) begin
                    nxt_regs[wr_idx][b*8 +: 8] = wdata_ff[b*8 +: 8];
                end
            end
        end
    end

    // Bus and register state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            waddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
            regs_ff <= REG_RST;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            regs_ff <= nxt_regs;
        end
    end

    // Register fields; the screen size reaches 2047 by 2047.
    assign depth = regs_ff[IDX_CTRL][CTRL_DEPTH_LSB +: 3];
    assign cur_en = regs_ff[IDX_CTRL][CTRL_CUR_EN];
    assign fsync = regs_ff[IDX_CTRL][CTRL_FSYNC];
    assign run = regs_ff[IDX_CTRL][CTRL_RUN];
    assign dual_scan_enable = regs_ff[IDX_CTRL][CTRL_DUAL_SCAN_ENABLE];
    assign scr_w = regs_ff[IDX_SCRN][0 +: COORD_W];
    assign scr_h = regs_ff[IDX_SCRN][XY_Y_LSB +: COORD_W];
    assign pwm_per = regs_ff[IDX_PWM_PER][PWM_W-1:0];
    assign pwm_duty = regs_ff[IDX_PWM_DUTY][PWM_W-1:0];
    assign cur_x = regs_ff[IDX_CUR_POS][0 +: COORD_W];
    assign cur_y = regs_ff[IDX_CUR_POS][XY_Y_LSB +: COORD_W];

    // Cursor sides beyond 64 are held at 64.
    always_comb begin
        cw = regs_ff[IDX_CUR_SIZE][0 +: 7];
        ch = regs_ff[IDX_CUR_SIZE][SIZE_H_LSB +: 7];
        if (cw > CUR_MAX) cw = CUR_MAX;
        if (ch > CUR_MAX) ch = CUR_MAX;
    end

    logic [WORD_W-1:0] fifo_data, w, cur_ff, nxt_cur;
    logic fifo_valid, fifo_ready, need_pop, adv, last, in_cur;
    logic [4:0] sub_ff, nxt_sub, bi;
    logic [PIX_W-1:0] raw, fin, pd_ff, nxt_pd;
    logic [15:0] hw;
    logic pv_ff, nxt_pv;
    logic [COORD_W-1:0] nxt_x, nxt_y, dx, dy;
    logic [1:0] code;

    // Four-word buffer between the fetch path and the unpacker.
    rpu_fifo #(.W(WORD_W), .D(FIFO_D)) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_data(word_data),
        .in_valid(word_valid),
        .in_ready(word_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready)
    );

    assign w = need_pop ? fifo_data : cur_ff;
    assign adv = run && (!pv_ff || pix_ready) && (!need_pop || fifo_valid);
    assign fifo_ready = adv && need_pop;
    assign pix_valid = pv_ff;
    assign pix_data = pd_ff;
    assign bi = {sub_ff[4:3], ~sub_ff[2:0]};
    assign hw = sub_ff[0] ? w[31:16] : w[15:0];

    // Pixel selection per depth; a new word is drawn at step 0, or at steps 0 to 2 for packed 24 bpp.
    always_comb begin
        need_pop = sub_ff == 5'h00;
        last = 1'b1;
        raw = w[23:0];
        case (depth)
            DEPTH_1: begin
                last = sub_ff == 5'h1F;
                raw = {23'h000000, w[bi]};
            end
            DEPTH_4: begin
                last = sub_ff == 5'h07;
                raw = {20'h00000, w[{sub_ff[2:1], ~sub_ff[0], 2'h0} +: 4]};
            end
            DEPTH_8: begin
                last = sub_ff == 5'h03;
                raw = {16'h0000, w[{sub_ff[1:0], 3'h0} +: 8]};
            end
            DEPTH_16: begin
                last = sub_ff == 5'h01;
                raw = {hw[15:11], 3'h0, hw[10:5], 2'h0, hw[4:0], 3'h0};
            end
            DEPTH_24P: begin
                need_pop = sub_ff != 5'h03;
                last = sub_ff == 5'h03;
                case (sub_ff[1:0])
                    2'h0: raw = w[23:0];
                    2'h1: raw = {w[15:0], cur_ff[31:24]};
                    2'h2: raw = {w[7:0], cur_ff[31:16]};
                    default: raw = cur_ff[31:8];
                endcase
            end
            default: raw = w[23:0];
        endcase
    end

    // Cursor window with right and bottom clipping, and its bitmap word.
    assign dx = x_ff - cur_x;
    assign dy = y_ff - cur_y;
    assign in_cur = cur_en && x_ff >= cur_x && y_ff >= cur_y
        && dx < {4'h0, cw} && dy < {4'h0, ch}
        && x_ff < scr_w && y_ff < scr_h;
    assign cur_rd_addr = {regs_ff[IDX_CUR_BASE][31:2], 2'h0}
        + {22'h000000, dy[5:0], dx[5:4], 2'h0};
    assign code = cur_rd_data[{dx[3:0], 1'b0} +: 2];

    // Overlay of the cursor onto the unpacked pixel.
    always_comb begin
        fin = raw;
        if (in_cur) begin
            case (code)
                CUR_INVERT: fin = ~raw;
                CUR_COLOUR1: fin = regs_ff[IDX_CUR_COL1][PIX_W-1:0];
                CUR_COLOUR2: fin = regs_ff[IDX_CUR_COL2][PIX_W-1:0];
                default: fin = raw;
            endcase
        end
    end

    // Pixel stage, step counter and raster position.
    always_comb begin
        nxt_pv = pv_ff;
        nxt_pd = pd_ff;
        nxt_sub = sub_ff;
        nxt_cur = cur_ff;
        nxt_x = x_ff;
        nxt_y = y_ff;
        if (pv_ff && pix_ready) nxt_pv = 1'b0;
        if (adv) begin
            nxt_pv = 1'b1;
            nxt_pd = fin;
            nxt_sub = last ? 5'h00 : sub_ff + 5'h01;
            if (need_pop) nxt_cur = fifo_data;
            if ({1'b0, x_ff} + 12'h001 >= {1'b0, scr_w}) begin
                nxt_x = '0;
                nxt_y = ({1'b0, y_ff} + 12'h001 >= {1'b0, scr_h}) ?
                    '0 : y_ff + 11'h001;
            end else begin
                nxt_x = x_ff + 11'h001;
            end
        end
        if (frame_start) begin
            nxt_sub = 5'h00;
            nxt_x = '0;
            nxt_y = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pv_ff <= 1'b0;
            pd_ff <= '0;
            sub_ff <= '0;
            cur_ff <= '0;
            x_ff <= '0;
            y_ff <= '0;
        end else begin
            pv_ff <= nxt_pv;
            pd_ff <= nxt_pd;
            sub_ff <= nxt_sub;
            cur_ff <= nxt_cur;
            x_ff <= nxt_x;
            y_ff <= nxt_y;
        end
    end

    logic [PWM_W-1:0] pcnt_ff, nxt_pcnt;
    logic bright_ff, nxt_bright;

    // Brightness counter, optionally restarted by each frame start.
    always_comb begin
        if ((fsync && frame_start)
            || {1'b0, pcnt_ff} + 17'h00001 >= {1'b0, pwm_per}) begin
            nxt_pcnt = '0;
        end else begin
            nxt_pcnt = pcnt_ff + 16'h0001;
        end
        nxt_bright = nxt_pcnt < pwm_duty;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pcnt_ff <= '0;
            bright_ff <= 1'b0;
        end else begin
            pcnt_ff <= nxt_pcnt;
            bright_ff <= nxt_bright;
        end
    end
    assign bright = bright_ff;

    // Checks on unpacking, cursor, brightness timing and the line wrap at the right edge.
    AST_PWM_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
        fsync && frame_start |=> pcnt_ff == '0 && bright_ff == (pwm_duty != '0))
        else $error("brightness counter not restarted at frame start");
    AST_PWM_DUTY: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) && $stable(pwm_duty) // Reset leaves the level low.
        |-> bright_ff == (pcnt_ff < pwm_duty))
        else $error("brightness level does not match duty");
    AST_DEPTH32: assert property (@(posedge aclk) disable iff (!aresetn)
        adv && depth == DEPTH_32 && !in_cur |=> pd_ff == $past(fifo_data[23:0]))
        else $error("32 bpp pixel wrong");
    AST_DEPTH16_HI: assert property (@(posedge aclk) disable iff (!aresetn)
        adv && depth == DEPTH_16 && sub_ff == 5'h01 && !in_cur
        |=> pd_ff[23:19] == $past(cur_ff[31:27]) && sub_ff == 5'h00)
        else $error("16 bpp second pixel wrong");
    AST_DEPTH24_P3: assert property (@(posedge aclk) disable iff (!aresetn)
        adv && depth == DEPTH_24P && sub_ff == 5'h03 && !in_cur
        |=> pd_ff == $past(cur_ff[31:8]) && !$past(fifo_ready))
        else $error("24 bpp fourth pixel wrong");
    AST_DEPTH1_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
        adv && depth == DEPTH_1 && sub_ff == 5'h00 && !in_cur
        |=> pd_ff[0] == $past(fifo_data[7]))
        else $error("1 bpp first pixel not the top bit");
    AST_DEPTH8_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        adv && depth == DEPTH_8 && sub_ff == 5'h03 && !frame_start
        |=> sub_ff == 5'h00)
        else $error("8 bpp does not take a new word after four pixels");
    AST_CUR_COLOUR1: assert property (@(posedge aclk) disable iff (!aresetn)
        adv && in_cur && code == CUR_COLOUR1
        |=> pd_ff == $past(regs_ff[IDX_CUR_COL1][PIX_W-1:0]))
        else $error("cursor colour 1 not shown");
    AST_RIGHT_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
        adv && !frame_start && x_ff == scr_w - 11'h001 && $stable(scr_w)
        |=> x_ff == '0)
        else $error("line does not wrap at the right edge");
endmodule : rpu_top

// ==== rtl/rpu_pkg.sv ====
package rpu_pkg;

    // Bus and datapath sizes.
    localparam int ADDR_W = 8;
    localparam int WORD_W = 32;
    localparam int PIX_W = 24;
    localparam int COORD_W = 11;
    localparam int PWM_W = 16;
    localparam int FIFO_D = 4;

    // Register indices; the byte offset is four times the index.
    localparam int NREG = 10;
    localparam int NREG_RW = 9;
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_SCRN = 4'h1;
    localparam logic [3:0] IDX_PWM_PER = 4'h2;
    localparam logic [3:0] IDX_PWM_DUTY = 4'h3;
    localparam logic [3:0] IDX_CUR_BASE = 4'h4;
    localparam logic [3:0] IDX_CUR_COL1 = 4'h5;
    localparam logic [3:0] IDX_CUR_COL2 = 4'h6;
    localparam logic [3:0] IDX_CUR_POS = 4'h7;
    localparam logic [3:0] IDX_CUR_SIZE = 4'h8;
    localparam logic [3:0] IDX_STATUS = 4'h9;

    // Field positions.
    localparam int CTRL_DEPTH_LSB = 0;
    localparam int CTRL_CUR_EN = 4;
    localparam int CTRL_FSYNC = 5;
    localparam int CTRL_DUAL_SCAN_ENABLE = 6;
    localparam int CTRL_RUN = 7;
    localparam int XY_Y_LSB = 16;
    localparam int SIZE_H_LSB = 8;

    // Values after reset: 8 bpp stopped, 1280 by 1024, 64 by 64 cursor.
    localparam logic [WORD_W-1:0] REG_RST [0:NREG_RW-1] = '{
        32'h0000_0002, 32'h0400_0500, 32'h0000_00FF, 32'h0000_0080,
        32'h0000_0000, 32'h0000_0000, 32'h00FF_FFFF, 32'h0000_0000,
        32'h0000_4040};

    // Pixel depth select codes.
    localparam logic [2:0] DEPTH_1 = 3'h0;
    localparam logic [2:0] DEPTH_4 = 3'h1;
    localparam logic [2:0] DEPTH_8 = 3'h2;
    localparam logic [2:0] DEPTH_16 = 3'h3;
    localparam logic [2:0] DEPTH_24P = 3'h4;
    localparam logic [2:0] DEPTH_32 = 3'h5;

    // Cursor pixel codes and the largest cursor side.
    localparam logic [1:0] CUR_CLEAR = 2'h0;
    localparam logic [1:0] CUR_INVERT = 2'h1;
    localparam logic [1:0] CUR_COLOUR1 = 2'h2;
    localparam logic [1:0] CUR_COLOUR2 = 2'h3;
    localparam logic [6:0] CUR_MAX = 7'h40;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rpu_pkg

// ==== rtl/rpu_fifo.sv ====
`timescale 1ns/1ps
module rpu_fifo #(
    parameter int W = 32,
    parameter int D = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(D);

    logic [W-1:0] mem_ff [0:D-1];
    logic [W-1:0] nxt_mem [0:D-1];
    logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready = cnt_ff != CNT_FULL;
    assign out_valid = cnt_ff != '0;
    assign out_data = mem_ff[rp_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap at the depth, and the count follows both ends.
    always_comb begin
        nxt_mem = mem_ff;
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_mem[wp_ff] = in_data;
            nxt_wp = (wp_ff == PTR_LAST) ? '0 : wp_ff + 1'b1;
        end
        if (pop) begin
            nxt_rp = (rp_ff == PTR_LAST) ? '0 : rp_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    // State registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
        mem_ff <= nxt_mem;
    end
endmodule : rpu_fifo

// ==== sim/rpu_panel.sv ====
`timescale 1ns/1ps
module rpu_panel (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [rpu_pkg::PIX_W-1:0] pix_data,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic slow
);
    import rpu_pkg::*;
    logic [PIX_W-1:0] q [$];
    // Takes a pixel at each edge with valid and ready high; a slow panel
    // stalls every other cycle, so the stream has to hold its pixel.
    always @(posedge aclk) begin
        if (!aresetn) begin
            pix_ready <= 1'h0;
        end else begin
            pix_ready <= slow ? !pix_ready : 1'h1;
            if (pix_valid && pix_ready) begin
                q.push_back(pix_data);
            end
        end
    end
endmodule : rpu_panel

// ==== sim/raster_pixel_unpack_cursor_tb_top.sv ====
`timescale 1ns/1ps
module raster_pixel_unpack_cursor_tb_top;
    import rpu_pkg::*;
    typedef struct {
        logic [7:0] ctl;
        int n;
        int idx;
        logic [PIX_W-1:0] exp;
    } rpu_row_t;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, word_valid = 1'h0;
    logic frame_start = 1'h0, slow = 1'h0;
    logic [WORD_W-1:0] wdata = 32'h0, word_data = 32'h0, rdata, v;
    logic [WORD_W-1:0] cur_rd_addr, cur_rd_data;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, word_ready;
    logic pix_valid, pix_ready, bright, dual_scan_enable;
    logic [1:0] bresp, rresp, rsp;
    logic [PIX_W-1:0] pix_data, px;
    logic [WORD_W-1:0] wd [0:2] = '{32'hA1B2C3D4, 32'h15263748, 32'h9ABCDEF0};
    int n_fail = 0;
    int checks_done = 0;
    int i;
    int k;
    rpu_row_t r;
    rpu_row_t rows [0:14] = '{
        '{8'h03, 6, 0, 24'hC078A0},
        '{8'h03, 6, 1, 24'hA03490},
        '{8'h04, 4, 1, 24'h3748A1},
        '{8'h04, 4, 2, 24'hF01526},
        '{8'h04, 4, 3, 24'h9ABCDE},
        '{8'h05, 3, 1, 24'h263748},
        '{8'h00, 96, 0, 24'h1},
        '{8'h00, 96, 26, 24'h1},
        '{8'h02, 12, 2, 24'hB2},
        '{8'h01, 24, 3, 24'h3},
        '{8'h13, 6, 0, 24'hC078A0},
        '{8'h13, 6, 1, 24'h5FCB6F},
        '{8'h13, 6, 2, 24'h123456},
        '{8'h13, 6, 3, 24'h654321},
        '{8'h13, 6, 4, 24'hD8DC80}};

    // Clock of 4 ns and a zero-latency cursor bitmap holding codes 0,1,2,3.
    always #2 aclk = ~aclk;
    assign cur_rd_data = (cur_rd_addr == 32'h0) ? 32'h000000E4 : 32'h0;

    rpu_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .word_data,
        .word_valid, .word_ready, .frame_start, .pix_data, .pix_valid,
        .pix_ready, .cur_rd_addr, .cur_rd_data, .bright, .dual_scan_enable);
    rpu_panel panel (.aclk, .aresetn, .pix_data, .pix_valid, .pix_ready,
        .slow);

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic tmo();
        n_fail++;
        $display("ERROR at %0t wait ran out", $time);
        finish_test();
    endtask : tmo

    // Write: address and data offered together, each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic da;
        logic dw;
        logic db;
        int j;
        da = 1'h0;
        dw = 1'h0;
        db = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (j = 0; j < 50 && !db; j++) begin
            @(negedge aclk);
            da |= awvalid && (awready === 1'h1);
            dw |= wvalid && (wready === 1'h1);
            if (bvalid === 1'h1) begin
                db = 1'h1;
                rsp = bresp;
            end
            @(posedge aclk);
            if (da) awvalid <= 1'h0;
            if (dw) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        if (!db) tmo();
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic da;
        logic db;
        int j;
        da = 1'h0;
        db = 1'h0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (j = 0; j < 50 && !db; j++) begin
            @(negedge aclk);
            da |= arvalid && (arready === 1'h1);
            if (rvalid === 1'h1) begin
                db = 1'h1;
                v = rdata;
                rsp = rresp;
            end
            @(posedge aclk);
            if (da) arvalid <= 1'h0;
        end
        rready <= 1'h0;
        if (!db) tmo();
    endtask : rd

    // Offers a frame-buffer word and holds it until the FIFO takes it.
    task automatic push(input logic [31:0] w);
        logic dn;
        int j;
        dn = 1'h0;
        word_data <= w;
        word_valid <= 1'h1;
        for (j = 0; j < 50 && !dn; j++) begin
            @(negedge aclk);
            dn = (word_ready === 1'h1);
            @(posedge aclk);
        end
        if (!dn) tmo();
    endtask : push

    task automatic pulse();
        @(posedge aclk);
        frame_start <= 1'h1;
        @(posedge aclk);
        frame_start <= 1'h0;
    endtask : pulse

    // Stops the stream, realigns it, clears the panel and starts again.
    task automatic start(input logic [7:0] c);
        wr(8'h00, {24'h0, c});
        pulse();
        panel.q.delete();
        wr(8'h00, {24'h0, c | 8'h80});
    endtask : start

    task automatic waitq(input int n);
        int j;
        for (j = 0; j < 500 && panel.q.size() < n; j++) @(negedge aclk);
        if (panel.q.size() < n) tmo();
        repeat (4) @(negedge aclk);
    endtask : waitq

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        // Reset values, an unmapped read and a write to the status word.
        for (i = 0; i < NREG; i++) begin
            rd(8'(i * 4));
            chk(v, (i < NREG_RW) ? REG_RST[i] : 32'h0);
            chk(rsp, RESP_OKAY);
        end
        rd(8'h28);
        chk(v, 32'h0);
        chk(rsp, RESP_SLVERR);
        wr(8'h24, 32'h1);
        chk(rsp, RESP_SLVERR);
        // A write with one byte lane enabled changes only that byte.
        wstrb <= 4'h2;
        wr(8'h14, 32'hAABBCCDD);
        wstrb <= 4'hF;
        rd(8'h14);
        chk(v, 32'h0000CC00);
        $display("register test done");
        // Cursor set up whole before any row enables it.
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h123456);
        wr(8'h18, 32'h654321);
        wr(8'h1C, 32'h0);
        wr(8'h20, 32'h0104);
        for (i = 0; i < 15; i++) begin
            r = rows[i];
            start(r.ctl);
            for (k = 0; k < 3; k++) push(wd[k]);
            word_valid <= 1'h0;
            waitq(r.n);
            chk(panel.q.size(), r.n);
            px = panel.q[r.idx];
            chk(px, r.exp);
            if (r.ctl[4]) chk(px, r.exp);
        end
        $display("pixel table done");
        // A 4 by 2 screen: the raster wraps and the cursor is clipped.
        wr(8'h04, 32'h0002_0004);
        wr(8'h1C, 32'h0001_0002);
        start(8'h12);
        for (k = 0; k < 3; k++) push(wd[k]);
        word_valid <= 1'h0;
        waitq(12);
        chk(panel.q.size(), 12);
        chk(panel.q[6], 24'h000026);
        chk(panel.q[7], 24'hFFFFEA);
        chk(panel.q[8], 24'h0000F0);
        rd(8'h24);
        chk(v, 32'h0001_0000);
        $display("clipping test done");
        // Fill the FIFO while stopped, then drain it into a stalling panel.
        start(8'h05);
        wr(8'h00, 32'h05);
        for (k = 0; k < 4; k++) push(wd[k % 3]);
        word_valid <= 1'h0;
        @(negedge aclk);
        chk(word_ready, 1'h0);
        wr(8'h00, 32'h85);
        slow <= 1'h1;
        waitq(4);
        chk(panel.q.size(), 4);
        chk(panel.q[3], 24'hB2C3D4);
        @(posedge aclk);
        slow <= 1'h0;
        $display("fifo test done");
        // Brightness locked to the frame start, then its duty measured.
        wr(8'h08, 32'h4);
        wr(8'h0C, 32'h1);
        wr(8'h00, 32'h62);
        chk(dual_scan_enable, 1'h1);
        for (i = 0; i < 2; i++) begin
            repeat (i + 1) @(posedge aclk);
            pulse();
            @(negedge aclk);
            chk(bright, 1'h1);
            @(negedge aclk);
            chk(bright, 1'h0);
        end
        k = 0;
        for (i = 0; i < 40; i++) begin
            @(negedge aclk);
            k += (bright === 1'h1);
        end
        chk(k, 10);
        $display("brightness test done");
        // A second reset in mid-run.
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        chk(bright, 1'h0);
        chk(pix_valid, 1'h0);
        rd(8'h00);
        chk(v, REG_RST[0]);
        $display("reset test done");
        finish_test();
    end
endmodule : raster_pixel_unpack_cursor_tb_top
